// File: ocd_pkg.sv
package ocd_pkg;

  // ----------------------------------------
  // Prefix and opcode bytes
  // ----------------------------------------
  localparam logic [7:0] OP_PFX_X = 8'hdd;
  localparam logic [7:0] OP_PFX_Y = 8'hfd;
  localparam logic [7:0] OP_PFX_ALT = 8'h76;
  localparam logic [7:0] OP_PFX_IOI = 8'hd3;
  localparam logic [7:0] OP_PFX_IOE = 8'hdb;
  localparam logic [7:0] OP_PFX_CB = 8'hcb;
  localparam logic [7:0] OP_PFX_ED = 8'hed;
  localparam logic [7:0] OP_BR_SHORT = 8'h18;
  localparam logic [7:0] OP_BR_ABS = 8'hc3;
  localparam logic [7:0] OP_CALL = 8'hcd;
  localparam logic [7:0] OP_FAR_CALL = 8'hcf;
  localparam logic [7:0] OP_EX_ALT = 8'he3;
  localparam logic [7:0] OP_COPY_UP = 8'hb0;
  localparam logic [7:0] OP_LD_XPC = 8'h67;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int CYC_W = 20;
  localparam logic [19:0] CYC_DEF = 20'h00002;
  localparam logic [19:0] CYC_BR_SHORT = 20'h00005;
  localparam logic [19:0] CYC_BR_ABS = 20'h00007;
  localparam logic [19:0] CYC_CALL = 20'h0000c;
  localparam logic [19:0] CYC_FAR_CALL = 20'h00013;
  localparam logic [19:0] CYC_BIT_IDX = 20'h0000a;
  localparam logic [19:0] CYC_BIT_MEM = 20'h00007;
  localparam logic [19:0] CYC_BIT_REG = 20'h00004;
  localparam logic [19:0] CYC_EX_ALT = 20'h00004;
  localparam logic [19:0] CYC_COPY_BASE = 20'h00006;
  localparam logic [19:0] CYC_COPY_STEP = 20'h00007;
  localparam logic [19:0] CYC_ED_SHORT = 20'h00004;
  localparam logic [19:0] CYC_LDW = 20'h00006;
  localparam logic [19:0] CYC_LDW_IDX = 20'h00008;
  localparam logic [19:0] CYC_RESTART = 20'h0000a;
  localparam logic [19:0] CYC_LD_IDX = 20'h00009;
  localparam logic [19:0] CYC_ST_IDX = 20'h0000a;
  localparam logic [19:0] CYC_PUSH = 20'h0000a;
  localparam logic [19:0] CYC_POP = 20'h00007;

  // ----------------------------------------
  // Word register select codes, memory operand register code and restart vector mask
  // ----------------------------------------
  localparam logic [3:0] WS_BC = 4'h0;
  localparam logic [3:0] WS_HL = 4'h2;
  localparam logic [3:0] WS_SP = 4'h3;
  localparam logic [3:0] WS_IX = 4'h4;
  localparam logic [3:0] WS_IY = 4'h5;
  localparam logic [3:0] WS_AF = 4'h6;
  localparam logic [3:0] WS_BC_ALT = 4'h7;
  localparam logic [3:0] WS_NONE = 4'hf;
  localparam logic [2:0] RS_MEM = 3'h6;
  localparam logic [7:0] VEC_OK_MASK = 8'hbc;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COPY = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0c;
  localparam int CTRL_HALT_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_OP, ST_CB, ST_ED, ST_XD, ST_XOP, ST_OPND, ST_FIN
  } ocd_st_t;

  typedef enum logic [1:0] {M_PLAIN, M_CB, M_ED, M_XCB} ocd_mode_t;

  typedef enum logic [4:0] {
    CL_NONE, CL_OTHER, CL_BR_SHORT, CL_BR_COND, CL_BR_ABS, CL_CALL,
    CL_FAR_CALL, CL_BIT, CL_EX, CL_COPY_UP, CL_PRIO_PUSH, CL_LD_XPC,
    CL_LD_WORD, CL_RESTART, CL_LD_REG, CL_LD_IDX, CL_ST_IDX, CL_PUSH,
    CL_POP, CL_LD_ALT, CL_ADC_WORD
  } ocd_cls_t;

endpackage : ocd_pkg

// File: ocd_top.sv
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module ocd_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Opcode byte stream
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic byte_ready_o,
  // Datapath state
  input wire logic flag_s_i,
  input wire logic flag_z_i,
  input wire logic flag_c_i,
  input wire logic [7:0] logic_res_i,
  input wire logic [15:0] idx_x_i,
  input wire logic [15:0] idx_y_i,
  // Decoded instruction
  output logic dec_valid_o,
  output ocd_pkg::ocd_cls_t dec_class_o,
  output logic [7:0] dec_opcode_o,
  output logic [2:0] reg_sel_o,
  output logic reg_sel_ok_o,
  output logic [3:0] word_sel_o,
  output logic [7:0] bit_mask_o,
  output logic cond_true_o,
  output logic [15:0] disp_o,
  output logic [15:0] eff_addr_o,
  output logic [15:0] imm_o,
  output logic [7:0] seg_ext_o,
  output logic [15:0] restart_vec_o,
  output logic restart_ok_o,
  output logic [1:0] prio_level_o,
  output logic [19:0] cycles_o,
  output logic alt_flags_o,
  output logic alt_reg_o,
  output logic [1:0] io_space_o,
  output logic io_src_o,
  output logic io_dst_o,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ocd_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ocd_pkg::AXI_AW-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  import ocd_pkg::*;

  typedef struct packed {
    ocd_st_t st;
    ocd_mode_t mode;
    logic [1:0] idx;
    logic alt;
    logic [1:0] io;
    logic [7:0] op;
    logic [1:0] need;
    logic [1:0] got;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic vld;
    ocd_cls_t cls;
    logic [7:0] opc;
    logic [2:0] rsel;
    logic rsel_ok;
    logic [3:0] wsel;
    logic [7:0] mask;
    logic cond;
    logic [15:0] disp;
    logic [15:0] ea;
    logic [15:0] imm;
    logic [7:0] seg;
    logic [15:0] vec;
    logic vec_ok;
    logic [1:0] lvl;
    logic [19:0] cyc;
    logic af;
    logic ar;
    logic [1:0] iosp;
    logic ios;
    logic iod;
    logic halt;
    logic [15:0] copy;
    logic [15:0] cnt;
    logic aw_have;
    logic w_have;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } ocd_state_t;

  ocd_state_t q;
  ocd_state_t n;
  logic take;
  logic [15:0] ix;
  logic [15:0] dsx;

  // ----------------------------------------
  // Field helpers
  // ----------------------------------------
  function automatic logic cond3(input logic [2:0] f, input logic s,
                                 input logic z, input logic c,
                                 input logic [3:0] up);
    logic r;
    r = 1'b0;
    unique case (f)
      3'b000: r = !z;
      3'b001: r = z;
      3'b010: r = !c;
      3'b011: r = c;
      3'b100: r = (up == 4'h0);
      3'b101: r = (up != 4'h0);
      3'b110: r = !s;
      3'b111: r = s;
    endcase
    return r;
  endfunction : cond3

  function automatic logic [3:0] wsel_of(input logic [1:0] c,
                                         input logic [1:0] pfx,
                                         input logic stk);
    logic [3:0] w;
    w = {2'b00, c};
    if (c == 2'b11 && stk) begin
      w = WS_AF;
    end else if (c == 2'b10 && pfx == 2'd1) begin
      w = WS_IX;
    end else if (c == 2'b10 && pfx == 2'd2) begin
      w = WS_IY;
    end
    return w;
  endfunction : wsel_of

  // Operand bytes still to fetch after the opcode
  function automatic logic [1:0] need_of(input logic [7:0] o,
                                         input logic [1:0] pfx);
    logic [1:0] k;
    k = 2'd0;
    if ((o[7:5] == 3'b001 && o[2:0] == 3'b000) || o == OP_BR_SHORT) begin
      k = 2'd1;
    end else if (o[7:6] == 2'b11 && o[2:0] == 3'b010) begin
      k = 2'd2;
    end else if (o == OP_BR_ABS || o == OP_CALL) begin
      k = 2'd2;
    end else if (o == OP_FAR_CALL) begin
      k = 2'd3;
    end else if (o[7:6] == 2'b00 && o[3:0] == 4'h1) begin
      k = 2'd2;
    end else if (pfx != 2'd0 && o[7:6] == 2'b01 &&
                 (o[2:0] == RS_MEM || o[5:3] == RS_MEM)) begin
      k = 2'd1;
    end
    return k;
  endfunction : need_of

  assign byte_ready_o = !q.halt && q.st != ST_FIN;
  assign take = byte_valid_i && byte_ready_o;
  assign ix = (q.idx == 2'd2) ? idx_y_i : idx_x_i;
  assign dsx = {{8{q.b1[7]}}, q.b1};

  assign s_axi_awready_o = !q.aw_have && !q.bv;
  assign s_axi_wready_o = !q.w_have && !q.bv;
  assign s_axi_arready_o = !q.rv;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.vld = 1'b0;

    // Address and data may arrive in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      n.aw_have = 1'b1;
      n.awa = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      n.w_have = 1'b1;
      n.wd = s_axi_wdata_i;
      n.ws = s_axi_wstrb_i;
    end
    if (q.aw_have && q.w_have && !q.bv) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OKAY;
      case (q.awa)
        REG_CTRL: if (q.ws[0]) n.halt = q.wd[CTRL_HALT_BIT];
        REG_COPY: begin
          if (q.ws[0]) n.copy[7:0] = q.wd[7:0];
          if (q.ws[1]) n.copy[15:8] = q.wd[15:8];
        end
        REG_COUNT, REG_LAST: n.br = RESP_OKAY;
        default: n.br = RESP_SLVERR;
      endcase
    end
    if (q.bv && s_axi_bready_i) n.bv = 1'b0;

    if (s_axi_arvalid_i && !q.rv) begin
      n.rv = 1'b1;
      n.rr = RESP_OKAY;
      case (s_axi_araddr_i)
        REG_CTRL: n.rd = {31'h0, q.halt};
        REG_COPY: n.rd = {16'h0, q.copy};
        REG_COUNT: n.rd = {16'h0, q.cnt};
        REG_LAST: n.rd = {3'h0, q.cls, 4'h0, q.cyc};
        default: begin
          n.rd = 32'h0;
          n.rr = RESP_SLVERR;
        end
      endcase
    end
    if (q.rv && s_axi_rready_i) n.rv = 1'b0;

    // Prefixes accumulate until an opcode arrives
    if (take) begin
      unique case (q.st)
        ST_OP: begin
          if (byte_i == OP_PFX_X) n.idx = 2'd1;
          else if (byte_i == OP_PFX_Y) n.idx = 2'd2;
          else if (byte_i == OP_PFX_ALT) n.alt = 1'b1;
          else if (byte_i == OP_PFX_IOI) n.io = 2'd1;
          else if (byte_i == OP_PFX_IOE) n.io = 2'd2;
          else if (byte_i == OP_PFX_CB) begin
            n.st = (q.idx != 2'd0) ? ST_XD : ST_CB;
          end else if (byte_i == OP_PFX_ED) n.st = ST_ED;
          else begin
            n.op = byte_i;
            n.mode = M_PLAIN;
            n.got = 2'd0;
            n.need = need_of(byte_i, q.idx);
            n.st = (n.need == 2'd0) ? ST_FIN : ST_OPND;
          end
        end
        ST_CB: begin
          n.op = byte_i;
          n.mode = M_CB;
          n.st = ST_FIN;
        end
        ST_ED: begin
          n.op = byte_i;
          n.mode = M_ED;
          n.st = ST_FIN;
        end
        ST_XD: begin
          n.b1 = byte_i;
          n.st = ST_XOP;
        end
        ST_XOP: begin
          n.op = byte_i;
          n.mode = M_XCB;
          n.st = ST_FIN;
        end
        ST_OPND: begin
          if (q.got == 2'd0) n.b1 = byte_i;
          if (q.got == 2'd1) n.b2 = byte_i;
          if (q.got == 2'd2) n.b3 = byte_i;
          n.got = q.got + 2'd1;
          if (n.got == q.need) n.st = ST_FIN;
        end
        ST_FIN: n.st = ST_FIN;
      endcase
    end

    // One idle cycle to decode keeps the byte path shallow
    if (q.st == ST_FIN) begin
      n.vld = 1'b1;
      n.cnt = q.cnt + 16'h1;
      n.opc = q.op;
      n.cls = CL_OTHER;
      n.rsel = q.op[5:3];
      n.wsel = WS_NONE;
      n.mask = 8'h01 << q.op[5:3];
      n.cond = 1'b1;
      n.disp = 16'h0;
      n.ea = 16'h0;
      n.imm = {q.b2, q.b1};
      n.seg = 8'h0;
      n.vec = 16'h0;
      n.vec_ok = 1'b0;
      n.lvl = 2'd0;
      n.cyc = CYC_DEF;
      n.af = 1'b0;
      n.ar = 1'b0;
      n.ios = 1'b0;
      n.iod = 1'b0;
      n.iosp = q.io;
      unique case (q.mode)
        M_PLAIN: begin
          if (q.need == 2'd1 && q.op[7:6] == 2'b00) begin
            n.cls = CL_BR_SHORT;
            n.cond = (q.op == OP_BR_SHORT) ? 1'b1 :
              cond3({1'b0, q.op[4:3]}, flag_s_i, flag_z_i, flag_c_i,
                    logic_res_i[7:4]);
            n.disp = dsx + 16'h0002;
            n.cyc = CYC_BR_SHORT;
          end else if (q.op[7:6] == 2'b11 && q.op[2:0] == 3'b010) begin
            n.cls = CL_BR_COND;
            n.cond = cond3(q.op[5:3], flag_s_i, flag_z_i, flag_c_i,
                           logic_res_i[7:4]);
            n.cyc = CYC_BR_ABS;
          end else if (q.op == OP_BR_ABS) begin
            n.cls = CL_BR_ABS;
            n.cyc = CYC_BR_ABS;
          end else if (q.op == OP_CALL) begin
            n.cls = CL_CALL;
            n.cyc = CYC_CALL;
          end else if (q.op == OP_FAR_CALL) begin
            n.cls = CL_FAR_CALL;
            n.seg = q.b3;
            n.cyc = CYC_FAR_CALL;
          end else if (q.op[7:6] == 2'b00 && q.op[3:0] == 4'h1) begin
            n.cls = CL_LD_WORD;
            n.wsel = wsel_of(q.op[5:4], q.idx, 1'b0);
            n.cyc = (q.idx != 2'd0) ? CYC_LDW_IDX : CYC_LDW;
            n.ar = q.alt;
          end else if (q.op == OP_EX_ALT) begin
            n.cls = CL_EX;
            n.cyc = q.alt ? CYC_EX_ALT : CYC_DEF;
            n.ar = q.alt;
          end else if (q.op[7:6] == 2'b11 && q.op[2:0] == 3'b111) begin
            n.cls = CL_RESTART;
            n.vec = {9'h0, q.op[5:3], 4'h0};
            n.vec_ok = VEC_OK_MASK[q.op[5:3]];
            n.cyc = CYC_RESTART;
          end else if (q.op[7:6] == 2'b11 && q.op[3:0] == 4'h5) begin
            n.cls = CL_PUSH;
            n.wsel = wsel_of(q.op[5:4], 2'd0, 1'b1);
            n.cyc = CYC_PUSH;
          end else if (q.op[7:6] == 2'b11 && q.op[3:0] == 4'h1) begin
            n.cls = CL_POP;
            n.wsel = wsel_of(q.op[5:4], 2'd0, 1'b1);
            n.cyc = CYC_POP;
            n.ar = q.alt;
          end else if (q.op[7:6] == 2'b01 && q.need == 2'd1) begin
            n.ea = ix + dsx;
            n.disp = dsx;
            if (q.op[2:0] == RS_MEM) begin
              n.cls = CL_LD_IDX;
              n.cyc = CYC_LD_IDX;
              n.ar = q.alt;
              n.ios = (q.io != 2'd0);
            end else begin
              n.cls = CL_ST_IDX;
              n.rsel = q.op[2:0];
              n.cyc = CYC_ST_IDX;
              n.iod = (q.io != 2'd0);
            end
          end else if (q.op[7:6] == 2'b01) begin
            n.cls = CL_LD_REG;
            n.ar = q.alt;
          end
        end
        M_CB: begin
          if (q.op[7:6] == 2'b01) begin
            n.cls = CL_BIT;
            n.rsel = q.op[2:0];
            n.cyc = (q.op[2:0] == RS_MEM) ? CYC_BIT_MEM : CYC_BIT_REG;
            n.af = q.alt;
            n.ios = (q.io != 2'd0) && (q.op[2:0] == RS_MEM);
          end
        end
        M_XCB: begin
          n.cls = (q.op[7:6] == 2'b01) ? CL_BIT : CL_OTHER;
          n.rsel = RS_MEM;
          n.disp = dsx;
          n.ea = ix + dsx;
          n.cyc = CYC_BIT_IDX;
          n.af = q.alt;
          n.ios = (q.io != 2'd0);
        end
        M_ED: begin
          if (q.op == OP_COPY_UP) begin
            n.cls = CL_COPY_UP;
            n.cyc = CYC_COPY_BASE +
              CYC_W'({4'h0, q.copy} * CYC_COPY_STEP);
            n.iod = (q.io != 2'd0);
          end else if (q.op == OP_LD_XPC) begin
            n.cls = CL_LD_XPC;
            n.cyc = CYC_ED_SHORT;
          end else if (q.op[7:5] == 3'b010 && q.op[2:0] == 3'b110) begin
            n.cls = CL_PRIO_PUSH;
            n.lvl = {q.op[3], q.op[4]};
            n.cyc = CYC_ED_SHORT;
          end else if (q.op[7:6] == 2'b01 && q.op[2:0] == 3'b001) begin
            n.cls = CL_LD_ALT;
            n.wsel = (q.op[5:4] == 2'b11) ? WS_NONE :
              WS_BC_ALT + {2'b00, q.op[5:4]};
            n.cyc = CYC_ED_SHORT;
          end else if (q.op[7:6] == 2'b01 && q.op[3:0] == 4'ha) begin
            n.cls = CL_ADC_WORD;
            n.wsel = wsel_of(q.op[5:4], 2'd0, 1'b0);
            n.cyc = CYC_ED_SHORT;
            n.af = q.alt;
            n.ar = q.alt;
          end
        end
      endcase
      n.rsel_ok = (n.rsel != RS_MEM);
      n.idx = 2'd0;
      n.alt = 1'b0;
      n.io = 2'd0;
      n.st = ST_OP;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dec_valid_o = q.vld;
  assign dec_class_o = q.cls;
  assign dec_opcode_o = q.opc;
  assign reg_sel_o = q.rsel;
  assign reg_sel_ok_o = q.rsel_ok;
  assign word_sel_o = q.wsel;
  assign bit_mask_o = q.mask;
  assign cond_true_o = q.cond;
  assign disp_o = q.disp;
  assign eff_addr_o = q.ea;
  assign imm_o = q.imm;
  assign seg_ext_o = q.seg;
  assign restart_vec_o = q.vec;
  assign restart_ok_o = q.vec_ok;
  assign prio_level_o = q.lvl;
  assign cycles_o = q.cyc;
  assign alt_flags_o = q.af;
  assign alt_reg_o = q.ar;
  assign io_space_o = q.iosp;
  assign io_src_o = q.ios;
  assign io_dst_o = q.iod;
  assign s_axi_bvalid_o = q.bv;
  assign s_axi_bresp_o = q.br;
  assign s_axi_rvalid_o = q.rv;
  assign s_axi_rdata_o = q.rd;
  assign s_axi_rresp_o = q.rr;

endmodule : ocd_top

// File: ocd_checker_asserts.sv
`timescale 1ns/1ns
module ocd_checker (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Datapath state
  input wire logic flag_s_i,
  input wire logic flag_z_i,
  input wire logic flag_c_i,
  input wire logic [7:0] logic_res_i,
  // Decode outputs
  input wire logic dec_valid_o,
  input wire ocd_pkg::ocd_cls_t dec_class_o,
  input wire logic [7:0] dec_opcode_o,
  input wire logic [2:0] reg_sel_o,
  input wire logic reg_sel_ok_o,
  input wire logic [7:0] bit_mask_o,
  input wire logic cond_true_o,
  input wire logic [15:0] restart_vec_o,
  input wire logic restart_ok_o,
  input wire logic [19:0] cycles_o
);
  import ocd_pkg::*;
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  wire dv = dec_valid_o;
  // Flags are taken in the decode cycle, one cycle before the pulse
  function automatic logic cf(logic [2:0] f, logic z, logic c, logic s, logic [7:0] u);
    case (f[2:1])
      2'b00: cf = z ^ !f[0];
      2'b01: cf = c ^ !f[0];
      2'b10: cf = (u[7:4] != 4'h0) ^ !f[0];
      default: cf = s ^ !f[0];
    endcase
  endfunction : cf
  a_bit_mask: assert property (dv && dec_class_o == CL_BIT |->
    bit_mask_o == 8'h01 << dec_opcode_o[5:3]) else $error("bit mask wrong");
  a_short_cond: assert property (dv && dec_class_o == CL_BR_SHORT &&
    dec_opcode_o[7:5] == 3'b001 |-> cycles_o == 20'h5 && cond_true_o == cf({1'b0,
    dec_opcode_o[4:3]}, $past(flag_z_i), $past(flag_c_i), $past(flag_s_i),
    $past(logic_res_i))) else $error("short branch wrong");
  a_abs_cond: assert property (dv && dec_class_o == CL_BR_COND &&
    dec_opcode_o[7:6] == 2'b11 |-> cycles_o == 20'h7 && cond_true_o ==
    cf(dec_opcode_o[5:3], $past(flag_z_i), $past(flag_c_i), $past(flag_s_i),
    $past(logic_res_i))) else $error("absolute branch wrong");
  a_reg_none: assert property (dv |-> reg_sel_ok_o == (reg_sel_o != 3'b110))
    else $error("register select flag wrong");
  a_restart_map: assert property (dv && dec_class_o == CL_RESTART |->
    restart_vec_o == {9'h000, dec_opcode_o[5:3], 4'h0} && restart_ok_o ==
    (dec_opcode_o[5:3] inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h7})) else $error("restart wrong");
  a_short_clk: assert property (dv && dec_class_o == CL_BR_SHORT |->
    cycles_o == 20'h5) else $error("short branch clocks wrong");
  a_call_clk: assert property (dv && dec_class_o == CL_CALL |->
    cycles_o == 20'hc ##1 !dv) else $error("call clocks wrong");
  a_far_clk: assert property (dv && dec_class_o == CL_FAR_CALL |->
    cycles_o == 20'h13) else $error("far call clocks wrong");
endmodule : ocd_checker
bind ocd_top ocd_checker i_chk (
  .clk_sys_i, .sys_rst_i, .flag_s_i, .flag_z_i, .flag_c_i, .logic_res_i, .dec_valid_o,
  .dec_class_o, .dec_opcode_o, .reg_sel_o, .reg_sel_ok_o, .bit_mask_o, .cond_true_o,
  .restart_vec_o, .restart_ok_o, .cycles_o
);

// File: ocd_fetch_model.sv
`timescale 1ns/1ns
module ocd_fetch_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Bench side
  input wire logic push_i,
  input wire logic [7:0] push_byte_i,
  input wire logic slow_i,
  // Decoder side
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] byte_o
);
  logic [7:0] q[$];
  // Released lines toggle so a stale byte never passes for a fresh one
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q.delete();
      valid_o <= 1'b0;
      byte_o <= 8'h5a;
    end else begin
      if (push_i) q.push_back(push_byte_i);
      if (valid_o && ready_i) void'(q.pop_front());
      if (!valid_o || ready_i) begin
        if (q.size() > 0 && !(slow_i && valid_o)) begin
          valid_o <= 1'b1;
          byte_o <= q[0];
        end else begin
          valid_o <= 1'b0;
          byte_o <= ~byte_o;
        end
      end
    end
  end
endmodule : ocd_fetch_model

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
  import ocd_pkg::*;
  logic clk_sys_i, sys_rst_i, push, slow, byte_valid_i, byte_ready_o, dec_valid_o;
  logic flag_s_i, flag_z_i, flag_c_i, alt_reg_o, io_dst_o, alt_flags_o, io_src_o;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0] bresp, rresp, prio_level_o, io_space_o;
  logic [7:0] pbyte, byte_i, logic_res_i, awa, ara, bit_mask_o, seg_ext_o;
  logic [15:0] idx_x_i, idx_y_i, disp_o, eff_addr_o, imm_o;
  logic [31:0] wd, rd;
  logic [3:0] word_sel_o;
  logic [19:0] cycles_o;
  ocd_cls_t dec_class_o;
  int failures = 0, total_checks = 0, cyc = 0, ndec = 0;
  ocd_top i_dut (
    .clk_sys_i, .sys_rst_i, .byte_valid_i, .byte_i, .byte_ready_o, .flag_s_i, .flag_z_i,
    .flag_c_i, .logic_res_i, .idx_x_i, .idx_y_i, .dec_valid_o, .dec_class_o,
    .dec_opcode_o(), .reg_sel_o(), .reg_sel_ok_o(), .word_sel_o, .bit_mask_o,
    .cond_true_o(), .disp_o, .eff_addr_o, .imm_o, .seg_ext_o, .restart_vec_o(),
    .restart_ok_o(), .prio_level_o, .cycles_o, .alt_flags_o, .alt_reg_o, .io_space_o,
    .io_src_o, .io_dst_o, .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp)
  );
  ocd_fetch_model i_fetch (
    .clk_sys_i, .sys_rst_i, .push_i(push), .push_byte_i(pbyte), .slow_i(slow),
    .ready_i(byte_ready_o), .valid_o(byte_valid_i), .byte_o(byte_i)
  );
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Whole run needs under 2000 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkd(input ocd_cls_t c, input logic [19:0] y);
    chk("class", 32'(c), 32'(dec_class_o));
    chk("cycles", 32'(y), 32'(cycles_o));
  endtask : chkd
  // Outputs are read at the edge, before that edge's updates land
  task automatic ins(input logic [7:0] q[$]);
    int n;
    foreach (q[i]) begin
      push <= 1'b1;
      pbyte <= q[i];
      @(posedge clk_sys_i);
    end
    push <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (dec_valid_o !== 1'b1 && n < 100);
    chk("dec_valid", 32'h1, 32'(dec_valid_o));
    ndec++;
  endtask : ins
  task automatic wrr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 100);
    br <= 1'b0;
    chk("bvalid", 32'h1, 32'(bv));
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge clk_sys_i);
  endtask : wrr
  task automatic rdr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 100);
    rr <= 1'b0;
    chk("rvalid", 32'h1, 32'(rv));
    chk("rdata", e, rd);
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge clk_sys_i);
  endtask : rdr
  initial begin
    sys_rst_i = 1'b1;
    {push, slow, awv, wv, br, arv, rr} = 7'h00;
    {flag_s_i, flag_z_i, flag_c_i} = 3'b110;
    logic_res_i = 8'h30;
    idx_x_i = 16'h1000;
    idx_y_i = 16'h2000;
    {pbyte, awa, ara} = 24'h000000;
    wd = 32'h0;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("ready", 32'h1, 32'(byte_ready_o));
    rdr(REG_CTRL, 32'h0, RESP_OKAY);
    wrr(REG_COPY, 32'h3, RESP_OKAY);
    rdr(REG_COPY, 32'h3, RESP_OKAY);
    wrr(REG_COUNT, 32'h55, RESP_OKAY);
    rdr(8'h10, 32'h0, RESP_SLVERR);
    ins('{8'hcd, 8'h34, 8'h12});
    chk("imm", 32'h1234, 32'(imm_o));
    slow <= 1'b1;
    ins('{8'hcf, 8'h78, 8'h56, 8'h9a});
    chk("seg", 32'h9a, 32'(seg_ext_o));
    slow <= 1'b0;
    ins('{8'h18, 8'hfc});
    chk("disp", 32'hfffe, 32'(disp_o));
    for (int i = 0; i < 4; i++) begin
      ins('{{3'b001, 2'(i), 3'b000}, 8'h10});
      chkd(CL_BR_SHORT, 20'h5);
    end
    for (int i = 0; i < 8; i++) begin
      logic_res_i <= i[1] ? 8'h05 : 8'h80;
      ins('{{2'b11, 3'(i), 3'b010}, 8'h00, 8'h80});
      chk("target", 32'h8000, 32'(imm_o));
      ins('{8'hcb, {2'b01, 3'(i), 3'b000}});
      chk("mask", 32'(8'h01 << i), 32'(bit_mask_o));
    end
    ins('{8'hd3, 8'h76, 8'hdd, 8'hcb, 8'h80, 8'h7e});
    chkd(CL_BIT, 20'ha);
    chk("ea", 32'h0f80, 32'(eff_addr_o));
    chk("alt_flags", 32'h1, 32'(alt_flags_o));
    chk("io_src", 32'h1, 32'(io_src_o));
    ins('{8'h76, 8'he3});
    chkd(CL_EX, 20'h4);
    chk("alt", 32'h1, 32'(alt_reg_o));
    ins('{8'hed, 8'hb0});
    chkd(CL_COPY_UP, 20'h1b);
    wrr(REG_COPY, 32'hffff, RESP_OKAY);
    ins('{8'hed, 8'hb0});
    chkd(CL_COPY_UP, 20'h6ffff);
    for (int i = 0; i < 4; i++) begin
      ins('{8'hed, {3'b010, i[0], i[1], 3'b110}});
      chkd(CL_PRIO_PUSH, 20'h4);
      chk("level", 32'(i), 32'(prio_level_o));
      ins('{{2'b00, 2'(i), 4'b0001}, 8'h34, 8'h12});
      chk("word", 32'(i), 32'(word_sel_o));
    end
    ins('{8'hed, 8'h67});
    chkd(CL_LD_XPC, 20'h4);
    ins('{8'hed, 8'h59});
    chk("word", 32'h8, 32'(word_sel_o));
    for (int i = 0; i < 2; i++) begin
      ins('{i ? 8'hfd : 8'hdd, 8'h21, 8'h00, 8'h00});
      chk("word", 32'(4 + i), 32'(word_sel_o));
      ins('{i ? 8'hdb : 8'hd3, 8'hdd, 8'h70, 8'h05});
      chk("io", 32'(i + 1), 32'(io_space_o));
      chk("io_dst", 32'h1, 32'(io_dst_o));
    end
    ins('{8'hf5});
    chk("word", 32'(WS_AF), 32'(word_sel_o));
    for (int i = 2; i < 8; i++) begin
      if (i != 6) begin
        ins('{{2'b11, 3'(i), 3'b111}});
        chkd(CL_RESTART, 20'ha);
      end
    end
    rdr(REG_LAST, 32'({5'(CL_RESTART), 4'h0, 20'ha}), RESP_OKAY);
    wrr(REG_CTRL, 32'h1, RESP_OKAY);
    chk("ready", 32'h0, 32'(byte_ready_o));
    wrr(REG_CTRL, 32'h0, RESP_OKAY);
    rdr(REG_COUNT, 32'(ndec), RESP_OKAY);
    wrap_up();
  end
endmodule : testbench
